// ### src/msd_decoder.sv
// memory space address decoder: window hit, core copy folding and target routing
`timescale 1ns/100ps
`include "msd_regs.svh"

module msd_decoder
    import msd_pkg::*;
(
    input  wire logic     core_clk_i,
    input  wire logic     arst_n_i,
    input  wire logic     req_valid_i,
    input  wire msd_req_s req_i,
    input  wire msd_cfg_s cfg_i,
    output logic          ans_valid_o,
    output msd_ans_s      ans_o,
    output logic          cfg_err_o,
    output logic          zbuf_ok_o
);
    logic [24:0] cmask;
    logic [24:0] hmask;
    logic        size_ok;
    logic        has_back;
    logic [24:0] coff;
    logic [24:0] foff;
    logic        fb_half;
    logic [4:0]  sub;
    logic        win_hit;
    logic        erom_hit;
    msd_ans_s    ans_d;
    msd_ans_s    ans_q;
    logic        vld_d;
    logic        vld_q;
    logic        err_d;
    logic        err_q;
    logic        zok_d;
    logic        zok_q;

    // core size from mask; unknown encodings fall back to the smallest core
    always_comb begin
        cmask   = `MSD_CMASK_4MB;
        size_ok = 1'b0;
        case (cfg_i.amask)
            `MSD_MASK_4MB: begin
                cmask   = `MSD_CMASK_4MB;
                size_ok = !cfg_i.deep;
            end
            `MSD_MASK_8MB: begin
                cmask   = `MSD_CMASK_8MB;
                size_ok = !cfg_i.deep;
            end
            `MSD_MASK_16MB: begin
                cmask   = `MSD_CMASK_16MB;
                size_ok = 1'b1;
            end
            `MSD_MASK_32MB: begin
                cmask   = `MSD_CMASK_32MB;
                size_ok = cfg_i.deep;
            end
            default: begin
                cmask   = `MSD_CMASK_4MB;
                size_ok = 1'b0;
            end
        endcase
    end

    // lower half of a core holds rom window and registers, upper half the frame buffer
    always_comb begin
        hmask    = cmask >> 1;
        has_back = cfg_i.deep || (cfg_i.amask == `MSD_MASK_16MB);
        coff     = req_i.addr[`MSD_CORE_W-1:0] & cmask;
        fb_half  = |(coff & ~hmask);
        sub      = coff[`MSD_SUB_LSB+4:`MSD_SUB_LSB] & hmask[`MSD_SUB_LSB+4:`MSD_SUB_LSB];
        foff     = coff & hmask;
        win_hit  = req_i.mem && !req_i.cfg
                   && (req_i.addr[31:`MSD_WIN_LSB] == cfg_i.base);
        erom_hit = req_i.erom && cfg_i.erom_en && !req_i.wr
                   && (req_i.addr[31:`MSD_EROM_W] == cfg_i.erom_base);
    end

    always_comb begin
        ans_d          = ans_q;
        vld_d          = 1'b0;
        err_d          = !size_ok;
        zok_d          = cfg_i.deep && (cfg_i.amask == `MSD_MASK_16MB);
        if (req_valid_i) begin
            vld_d          = 1'b1;
            ans_d.tgt      = MSD_TGT_NONE;
            ans_d.refused  = 1'b0;
            ans_d.fb_off   = '0;
            ans_d.reg_idx  = '0;
            ans_d.arom_off = '0;
            ans_d.erom_off = '0;
            if (erom_hit) begin
                ans_d.tgt      = MSD_TGT_EROM;
                ans_d.erom_off = req_i.addr[`MSD_EROM_W-1:0];
            end else if (win_hit) begin
                if (fb_half || (sub != `MSD_SUB_ROM && sub != `MSD_SUB_REG)) begin
                    // reserved lower-half regions fold onto the buffers
                    ans_d.fb_off = foff;
                    if (has_back && foff[`MSD_CORE_W-2] == 1'b0 && |(hmask >> 1)
                        && |(foff & ~(hmask >> 1))) begin
                        ans_d.tgt = MSD_TGT_BACK;
                    end else begin
                        ans_d.tgt = MSD_TGT_DISP;
                    end
                end else if (sub == `MSD_SUB_ROM) begin
                    ans_d.tgt      = MSD_TGT_AROM;
                    ans_d.arom_off = coff[`MSD_SUB_LSB-1:0];
                    ans_d.refused  = req_i.wr || (req_i.be != `MSD_BE_DWORD);
                end else begin
                    ans_d.tgt     = MSD_TGT_REGS;
                    ans_d.reg_idx = coff[`MSD_REG_IDX_MSB:`MSD_REG_IDX_LSB];
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ans_q <= '{tgt: MSD_TGT_NONE, default: '0};
            vld_q <= 1'b0;
            err_q <= 1'b0;
            zok_q <= 1'b0;
        end else begin
            ans_q <= ans_d;
            vld_q <= vld_d;
            err_q <= err_d;
            zok_q <= zok_d;
        end
    end

    assign ans_valid_o = vld_q;
    assign ans_o       = ans_q;
    assign cfg_err_o   = err_q;
    assign zbuf_ok_o   = zok_q;

    a_window_miss: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        req_valid_i && req_i.mem && !req_i.erom
        && req_i.addr[31:`MSD_WIN_LSB] != cfg_i.base
        |=> ans_valid_o && ans_o.tgt == MSD_TGT_NONE)
        else $error("access outside the window was claimed");

    a_config_skip: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        req_valid_i && req_i.cfg && !req_i.erom |=> ans_o.tgt == MSD_TGT_NONE)
        else $error("configuration cycle decoded as memory");

    a_copy_alias: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        ##1 req_valid_i && $past(req_valid_i) && $stable(cfg_i) && !req_i.erom
        && !$past(req_i.erom) && $stable(req_i.mem) && $stable(req_i.cfg)
        && $stable(req_i.wr) && $stable(req_i.be)
        && req_i.addr[31:`MSD_WIN_LSB] == $past(req_i.addr[31:`MSD_WIN_LSB])
        && (req_i.addr[24:0] & cmask) == ($past(req_i.addr[24:0]) & $past(cmask))
        |=> $stable(ans_o))
        else $error("two core copies decoded differently");

    a_size_check: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        !cfg_i.deep && (cfg_i.amask == `MSD_MASK_4MB || cfg_i.amask == `MSD_MASK_8MB
        || cfg_i.amask == `MSD_MASK_16MB) |=> !cfg_err_o)
        else $error("supported shallow core size flagged");

    a_deep_size: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        cfg_i.deep && cfg_i.amask != `MSD_MASK_16MB && cfg_i.amask != `MSD_MASK_32MB
        |=> cfg_err_o)
        else $error("unsupported deep core size not flagged");

    a_arom_dword: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        ans_valid_o && ans_o.tgt == MSD_TGT_AROM
        |-> ans_o.refused == ($past(req_i.wr) || $past(req_i.be) != `MSD_BE_DWORD))
        else $error("alternate rom access check wrong");

    a_reg_index: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        req_valid_i && req_i.mem && !req_i.cfg && !req_i.erom
        && req_i.addr[31:`MSD_WIN_LSB] == cfg_i.base
        && (req_i.addr[24:0] & cmask & ~(cmask >> 1)) == 25'h0000000
        && req_i.addr[24:20] == `MSD_SUB_REG
        |=> ans_o.tgt == MSD_TGT_REGS && !ans_o.refused
        && ans_o.reg_idx == $past(req_i.addr[8:2]))
        else $error("register alias index wrong");

    a_erom_byte: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        req_valid_i && req_i.erom && cfg_i.erom_en && !req_i.wr
        && req_i.addr[31:`MSD_EROM_W] == cfg_i.erom_base
        |=> ans_o.tgt == MSD_TGT_EROM && ans_o.erom_off == $past(req_i.addr[17:0]))
        else $error("expansion rom byte offset wrong");

    a_depth_buf: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        zbuf_ok_o |-> $past(cfg_i.deep) && $past(cfg_i.amask) == `MSD_MASK_16MB)
        else $error("depth buffer allowed on wrong size");

    a_fb_fold: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        ans_valid_o && (ans_o.tgt == MSD_TGT_DISP || ans_o.tgt == MSD_TGT_BACK)
        |-> ans_o.fb_off == ($past(req_i.addr[24:0]) & ($past(cmask) >> 1)))
        else $error("frame buffer offset not folded");

    a_answer_next: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        req_valid_i |=> ans_valid_o)
        else $error("request not answered on the next cycle");

    a_idle_quiet: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        !req_valid_i |=> !ans_valid_o)
        else $error("answer given without a request");

    a_back_route: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        ans_valid_o && ans_o.tgt == MSD_TGT_BACK
        |-> $past(cfg_i.deep) || $past(cfg_i.amask) == `MSD_MASK_16MB)
        else $error("back buffer decoded without a back buffer");
endmodule

// ### common/msd_regs.svh
// constants for the memory space address decoder
`ifndef MSD_REGS_SVH
`define MSD_REGS_SVH
`define MSD_WIN_LSB      27
`define MSD_CORE_W       25
`define MSD_SUB_LSB      20
`define MSD_MASK_4MB     3'h0
`define MSD_MASK_8MB     3'h4
`define MSD_MASK_16MB    3'h6
`define MSD_MASK_32MB    3'h7
`define MSD_CMASK_4MB    25'h03fffff
`define MSD_CMASK_8MB    25'h07fffff
`define MSD_CMASK_16MB   25'h0ffffff
`define MSD_CMASK_32MB   25'h1ffffff
`define MSD_SUB_ROM      5'h00
`define MSD_SUB_REG      5'h01
`define MSD_REG_IDX_LSB  2
`define MSD_REG_IDX_MSB  8
`define MSD_EROM_W       18
`define MSD_BE_DWORD     4'hf
`endif

// ### common/msd_pkg.sv
// types shared by the memory space address decoder
package msd_pkg;
    typedef enum logic [2:0] {
        MSD_TGT_NONE,
        MSD_TGT_DISP,
        MSD_TGT_BACK,
        MSD_TGT_AROM,
        MSD_TGT_REGS,
        MSD_TGT_EROM
    } msd_tgt_e;

    typedef struct packed {
        logic        mem;
        logic        erom;
        logic        cfg;
        logic        wr;
        logic [3:0]  be;
        logic [31:0] addr;
    } msd_req_s;

    typedef struct packed {
        logic [4:0]  base;
        logic [13:0] erom_base;
        logic        erom_en;
        logic        deep;
        logic [2:0]  amask;
    } msd_cfg_s;

    typedef struct packed {
        msd_tgt_e    tgt;
        logic        refused;
        logic [24:0] fb_off;
        logic [6:0]  reg_idx;
        logic [19:0] arom_off;
        logic [17:0] erom_off;
    } msd_ans_s;
endpackage

// ### tb/msd_master.sv
// bus master model that issues memory, rom and config cycles to the decoder
`timescale 1ns/100ps

module msd_master
    import msd_pkg::*;
(
    input  wire logic core_clk_i,
    output logic      req_valid_o,
    output msd_req_s  req_o
);
    initial begin
        req_valid_o = 1'h0;
        req_o       = '0;
    end

    // called just after an edge; holds the cycle up to the edge that takes it
    // only plain memory, rom and config cycles, never fill traffic to dram back buffers
    task automatic send(input msd_req_s r);
        req_valid_o = 1'h1;
        req_o       = r;
        @(posedge core_clk_i);
        #1;
    endtask

    // a released bus shows the inverse of its last value, not a held copy
    task automatic idle();
        req_valid_o = 1'h0;
        req_o       = ~req_o;
    endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench for the memory space address decoder
`timescale 1ns/100ps

module tb_top
    import msd_pkg::*;
;
    `define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
        $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end

    typedef struct packed {
        logic [3:0]  kind;
        logic [3:0]  be;
        logic [31:0] addr;
        logic [3:0]  ad;
        msd_tgt_e    t;
        logic [25:0] ro;
    } msd_row_s;

    logic        core_clk_i, arst_n_i, req_valid_i, ans_valid_o, cfg_err_o, zbuf_ok_o;
    msd_req_s    req_i;
    msd_cfg_s    cfg_i;
    msd_ans_s    ans_o;
    msd_ans_s    hold;
    msd_row_s    rows [16];
    logic [24:0] got;
    int          err_total;
    int          cmp_count;

    msd_master m (.core_clk_i(core_clk_i), .req_valid_o(req_valid_i), .req_o(req_i));

    msd_decoder uut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .cfg_i(cfg_i), .ans_valid_o(ans_valid_o), .ans_o(ans_o),
        .cfg_err_o(cfg_err_o), .zbuf_ok_o(zbuf_ok_o));

    initial begin
        core_clk_i = 1'h0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic test_done();
        $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_total++;
        test_done();
    end

    initial begin
        err_total = 0;
        cmp_count = 0;
        arst_n_i  = 1'h0;
        cfg_i     = {5'h03, 14'h0a00, 1'h1, 1'h0, 3'h0};
        // kind = mem, erom, cfg, wr; ad = amask, deep; ro = refused, offset
        rows[0]  = {4'h8, 4'hf, 32'h18100040, 4'h0, MSD_TGT_REGS, 26'h10};
        rows[1]  = {4'h8, 4'hf, 32'h19500040, 4'h0, MSD_TGT_REGS, 26'h10};
        rows[2]  = {4'h8, 4'h1, 32'h1f900240, 4'h0, MSD_TGT_REGS, 26'h10};
        rows[3]  = {4'h8, 4'hf, 32'h18200010, 4'h0, MSD_TGT_DISP, 26'h10};
        rows[4]  = {4'h8, 4'hf, 32'h18000100, 4'h0, MSD_TGT_AROM, 26'h100};
        rows[5]  = {4'h9, 4'hf, 32'h18000100, 4'h0, MSD_TGT_AROM, 26'h2000100};
        rows[6]  = {4'h8, 4'h3, 32'h18000100, 4'h0, MSD_TGT_AROM, 26'h2000100};
        rows[7]  = {4'h8, 4'hf, 32'h20000000, 4'h0, MSD_TGT_NONE, 26'h0};
        rows[8]  = {4'h8, 4'hf, 32'h17fffffc, 4'h0, MSD_TGT_NONE, 26'h0};
        rows[9]  = {4'h2, 4'hf, 32'h18100040, 4'h0, MSD_TGT_NONE, 26'h0};
        rows[10] = {4'h8, 4'hf, 32'h18c00020, 4'hd, MSD_TGT_BACK, 26'h400020};
        rows[11] = {4'h8, 4'hf, 32'h19000004, 4'hf, MSD_TGT_DISP, 26'h4};
        rows[12] = {4'h8, 4'hf, 32'h18300008, 4'h8, MSD_TGT_DISP, 26'h300008};
        rows[13] = {4'h4, 4'h1, 32'h28000123, 4'h0, MSD_TGT_EROM, 26'h123};
        rows[14] = {4'h5, 4'h1, 32'h28000123, 4'h0, MSD_TGT_NONE, 26'h0};
        rows[15] = {4'h8, 4'hf, 32'h18e00008, 4'hc, MSD_TGT_BACK, 26'h600008};
        #1;
        `CHK({ans_valid_o, ans_o.tgt, cfg_err_o}, {1'h0, MSD_TGT_NONE, 1'h0});
        repeat (2) @(posedge core_clk_i);
        #1 arst_n_i = 1'h1;
        // back to back: each answer is checked 1 ns after the edge that takes it, before the next request is driven
        foreach (rows[i]) begin
            {cfg_i.amask, cfg_i.deep} = rows[i].ad;
            m.send({rows[i].kind, rows[i].be, rows[i].addr});
            case (rows[i].t)
                MSD_TGT_REGS: got = 25'(ans_o.reg_idx);
                MSD_TGT_AROM: got = 25'(ans_o.arom_off);
                MSD_TGT_EROM: got = 25'(ans_o.erom_off);
                default:      got = ans_o.fb_off;
            endcase
            `CHK({ans_valid_o,ans_o.tgt,ans_o.refused,got}, {1'h1,rows[i].t,rows[i].ro});
        end
        hold = ans_o;
        m.idle();
        @(posedge core_clk_i);
        #1;
        `CHK({ans_valid_o, ans_o}, {1'h0, hold});
        $display("test rows done");
        for (int k = 0; k < 16; k++) begin
            cfg_i.deep  = k[3];
            cfg_i.amask = k[2:0];
            @(posedge core_clk_i);
            #1;
            `CHK(cfg_err_o, !(k[3] ? (k[2:0] >= 6) : (k[2:0] inside {0, 4, 6})));
            `CHK(zbuf_ok_o, k == 14);
        end
        // a disabled expansion rom must not claim its own address range
        cfg_i.erom_en = 1'h0;
        m.send({4'h4, 4'h1, 32'h28000123});
        `CHK({ans_valid_o, ans_o.tgt, ans_o.erom_off}, {1'h1, MSD_TGT_NONE, 18'h0});
        cfg_i.erom_en = 1'h1;
        $display("test cfg sweep done");
        {cfg_i.amask, cfg_i.deep} = 4'hd;
        m.send({4'h8, 4'hf, 32'h18100040});
        arst_n_i = 1'h0;
        #1;
        `CHK({ans_valid_o, ans_o.tgt, zbuf_ok_o}, {1'h0, MSD_TGT_NONE, 1'h0});
        @(posedge core_clk_i);
        #1 arst_n_i = 1'h1;
        m.send({4'h8, 4'hf, 32'h18100044});
        `CHK({ans_valid_o, ans_o.tgt, ans_o.reg_idx}, {1'h1, MSD_TGT_REGS, 7'h11});
        m.idle();
        $display("test reset done");
        test_done();
    end
endmodule
